// ==== pkg/dsd_pkg.sv ====
package dsd_pkg;

   ////////////////////////////////////////////////////////////////////////////////
   // clock and timebase
   localparam int unsigned CLK_PERIOD_NS      = 4;
   localparam int unsigned TICK_US            = 7900;
   localparam int unsigned DIAG_TICK_US       = 10500;
   localparam int unsigned EMIT_PULSE_US      = 100;
   localparam int unsigned TICK_CYCLES        = TICK_US * 1000 / CLK_PERIOD_NS;
   localparam int unsigned DIAG_TICK_CYCLES   = DIAG_TICK_US * 1000 / CLK_PERIOD_NS;
   // least time: round up
   localparam int unsigned EMIT_PULSE_CYCLES  =
      (EMIT_PULSE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   ////////////////////////////////////////////////////////////////////////////////
   // standby cycle, counted in timebase ticks
   localparam int unsigned CHECK_PERIOD_MS    = 32000;
   localparam int unsigned CHIRP_OFFSET_MS    = 16200;
   localparam int unsigned DISCHARGE_MS       = 1000;
   localparam int unsigned CYCLE_TICKS        = CHECK_PERIOD_MS * 1000 / TICK_US;
   localparam int unsigned OFFSET_TICKS       = CHIRP_OFFSET_MS * 1000 / TICK_US;
   localparam int unsigned DISCHARGE_TICKS    =
      (DISCHARGE_MS * 1000 + TICK_US - 1) / TICK_US;
   localparam int unsigned PHASE_W            = 12;
   localparam logic [11:0] LED_PHASE          = 12'h000;
   localparam logic [11:0] SUPPLY_CHIRP_PHASE = 12'h001;
   localparam logic [11:0] CHAMBER_TEST_PHASE = 12'h002;
   localparam logic [11:0] CHAMBER_CHIRP_PHASE = SUPPLY_CHIRP_PHASE + OFFSET_TICKS[11:0];
   localparam logic [11:0] LAST_PHASE         = CYCLE_TICKS[11:0] - 12'h001;
   localparam logic [1:0]  FAIL_LIMIT         = 2'h2;

   ////////////////////////////////////////////////////////////////////////////////
   // register map, byte addresses
   localparam logic [3:0]  REG_CTRL           = 4'h0;
   localparam logic [3:0]  REG_STATUS         = 4'h4;
   localparam logic [3:0]  REG_PHASE          = 4'h8;
   localparam int unsigned CTRL_EXT_CLK_BIT   = 0;
   localparam int unsigned CTRL_CHECK_EN_BIT  = 1;
   localparam int unsigned CTRL_FAIL_CLR_BIT  = 2;
   localparam logic        CTRL_EXT_CLK_RST   = 1'h0;
   localparam logic        CTRL_CHECK_EN_RST  = 1'h1;

   ////////////////////////////////////////////////////////////////////////////////
   // operating modes, gray coded
   typedef enum logic [1:0] {
      DSD_STANDBY = 2'h0,
      DSD_LOCAL   = 2'h1,
      DSD_REMOTE  = 2'h3,
      DSD_DIAG    = 2'h2
   } dsd_mode_t;

endpackage : dsd_pkg

// ==== rtl/dsd_timebase.sv ====
`timescale 1ns/10ps
module dsd_timebase #(
   parameter int unsigned TICK_CYCLES  = dsd_pkg::TICK_CYCLES,
   parameter int unsigned DIAG_CYCLES  = dsd_pkg::DIAG_TICK_CYCLES,
   parameter int unsigned PULSE_CYCLES = dsd_pkg::EMIT_PULSE_CYCLES
) (
   // clock and reset
   input  wire logic clk_in,
   input  wire logic rst_in,
   // period selection
   input  wire logic diag_in,
   input  wire logic ext_sel_in,
   input  wire logic ext_edge_in,
   // timing outputs
   output logic      tick_out,
   output logic      window_out
);

   logic [31:0] div_cnt;
   logic [31:0] win_cnt;
   logic [31:0] period;

   generate
      if (TICK_CYCLES < 2 || DIAG_CYCLES < 2 || PULSE_CYCLES < 1 ||
          PULSE_CYCLES >= TICK_CYCLES || PULSE_CYCLES >= DIAG_CYCLES) begin : g_bad
         $error("dsd_timebase: pulse must be shorter than both periods");
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////////
   assign period   = diag_in ? DIAG_CYCLES : TICK_CYCLES;
   // >= so a shorter period after a mode change still wraps
   assign tick_out = ext_sel_in ? ext_edge_in : (div_cnt >= period - 32'h1);
   assign window_out = (win_cnt != PULSE_CYCLES);

   always_ff @(posedge clk_in) begin
      if (rst_in || tick_out) begin
         div_cnt <= 32'h0;
      end else begin
         div_cnt <= div_cnt + 32'h1;
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         win_cnt <= PULSE_CYCLES;
      end else if (tick_out) begin
         win_cnt <= 32'h0;
      end else if (win_cnt != PULSE_CYCLES) begin
         win_cnt <= win_cnt + 32'h1;
      end
   end

endmodule : dsd_timebase

// ==== rtl/dsd_supervisor.sv ====
// The placing of the registers and the Avalon-MM slave port were left to the implementer.
`timescale 1ns/10ps
// Notes on behaviour
// - latch supply-low at end of indicator pulse
// - supply-low chirp one tick every cycle
// - chamber test every cycle at high gain
// - two failed chamber tests start chirping
// - supply chirp next to pulse, chamber later
// - no checks during local or remote alarm
// - below-ground test input enters diagnostic mode
// - diagnostic: chamber supply on, emitter every tick
// - diagnostic: interconnect released, high routes amplifier
// - threshold input picks gain and output pin
// - diagnostic amplification only during emitter pulse
// - feedback high adds hysteresis at normal gain
// - diagnostic mode accepts external oscillator clock
// - diagnostic horn pin shows smoke integrator
// - diagnostic indicator shows supply-low directly
// - no smoke sampling while horn sounds
// - local horn cycles complete, remote may cut
// - discharge only after local alarm
// - standby intervals counted from 7.9 ms tick
// - indicator pulse one tick every cycle
// - discharge enabled for one second after local
module dsd_supervisor #(
   parameter int unsigned TICK_CYCLES  = dsd_pkg::TICK_CYCLES,
   parameter int unsigned DIAG_CYCLES  = dsd_pkg::DIAG_TICK_CYCLES,
   parameter int unsigned PULSE_CYCLES = dsd_pkg::EMIT_PULSE_CYCLES,
   parameter int unsigned HORN_CYCLE   = 64,
   parameter int unsigned HORN_ON      = 32
) (
   // clock and reset
   input  wire logic        clk_in,
   input  wire logic        rst_in,
   // avalon-mm slave
   input  wire logic [3:0]  avs_address_in,
   input  wire logic        avs_read_in,
   input  wire logic        avs_write_in,
   input  wire logic [31:0] avs_writedata_in,
   input  wire logic [3:0]  avs_byteenable_in,
   output logic [31:0]      avs_readdata_out,
   output logic             avs_waitrequest_out,
   // comparator results and alarm state
   input  wire logic        supply_low_in,
   input  wire logic        chamber_fail_in,
   input  wire logic        smoke_integrator_in,
   input  wire logic        local_alarm_in,
   input  wire logic        remote_alarm_in,
   // test fixture and pins
   input  wire logic        test_below_ground_in,
   input  wire logic        supply_threshold_input_in,
   input  wire logic        feed_in,
   input  wire logic        ext_osc_in,
   // interconnect line
   input  wire logic        io_in,
   output logic             io_out,
   output logic             io_oe_n_out,
   output logic             io_discharge_out,
   // chamber and amplifier control
   output logic             chamber_supply_out,
   output logic             emitter_pulse_drive_out,
   output logic             photo_amp_en_out,
   output logic             high_gain_out,
   output logic             hysteresis_out,
   output logic             first_gain_pin_out,
   output logic             second_gain_pin_out,
   // annunciation
   output logic             horn_drive_pin_out,
   output logic             indicator_out,
   output logic             smoke_sample_inhibit_out,
   output logic             diag_mode_out
);

   generate
      if (HORN_CYCLE < 2 || HORN_ON < 1 || HORN_ON >= HORN_CYCLE ||
          HORN_CYCLE > 65535) begin : g_bad
         $error("dsd_supervisor: horn on time must be inside the horn cycle");
      end
   endgenerate

   dsd_pkg::dsd_mode_t mode;
   dsd_pkg::dsd_mode_t next_mode;
   logic [11:0]  phase;
   logic         tick;
   logic         window;
   logic         ext_prev;
   logic         ext_edge;
   logic         ext_sel;
   logic         ctrl_ext_clk;
   logic         ctrl_check_en;
   logic         fail_clr;
   logic         supply_low_held;
   logic [1:0]   fail_count;
   logic [15:0]  horn_cnt;
   logic         horn_run;
   logic         horn_local;
   logic [7:0]   dis_cnt;
   logic         standby_check;
   logic         diag;
   logic         alarm_horn;
   logic         supply_chirp;
   logic         chamber_chirp;
   logic         chamber_test;
   logic         horn_now;
   logic         route;
   logic         ack;
   logic         wr_ctrl;
   logic [31:0]  next_readdata;

   ////////////////////////////////////////////////////////////////////////////////
   // timebase

   assign ext_edge = ext_osc_in & ~ext_prev;
   assign ext_sel  = diag & ctrl_ext_clk;

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         ext_prev <= 1'h0;
      end else begin
         ext_prev <= ext_osc_in;
      end
   end

   dsd_timebase #(
      .TICK_CYCLES  (TICK_CYCLES),
      .DIAG_CYCLES  (DIAG_CYCLES),
      .PULSE_CYCLES (PULSE_CYCLES)
   ) u_timebase (
      .clk_in       (clk_in),
      .rst_in       (rst_in),
      .diag_in      (diag),
      .ext_sel_in   (ext_sel),
      .ext_edge_in  (ext_edge),
      .tick_out     (tick),
      .window_out   (window)
   );

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         phase <= 12'h000;
      end else if (tick) begin
         phase <= (phase == dsd_pkg::LAST_PHASE) ? 12'h000 : phase + 12'h001;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // mode

   assign diag = (mode == dsd_pkg::DSD_DIAG);

   always_comb begin
      next_mode = mode;
      unique case (mode)
         dsd_pkg::DSD_DIAG: begin
            next_mode = dsd_pkg::DSD_DIAG;
         end
         dsd_pkg::DSD_STANDBY, dsd_pkg::DSD_LOCAL, dsd_pkg::DSD_REMOTE: begin
            // sampled on an internal clock tick
            if (tick && test_below_ground_in) begin
               next_mode = dsd_pkg::DSD_DIAG;
            end else if (local_alarm_in) begin
               next_mode = dsd_pkg::DSD_LOCAL;
            end else if (remote_alarm_in) begin
               next_mode = dsd_pkg::DSD_REMOTE;
            end else begin
               next_mode = dsd_pkg::DSD_STANDBY;
            end
         end
      endcase
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         mode <= dsd_pkg::DSD_STANDBY;
      end else begin
         mode <= next_mode;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // supervision checks

   assign standby_check = (mode == dsd_pkg::DSD_STANDBY) & ctrl_check_en;
   // high gain during the test tick
   assign chamber_test  = standby_check & (phase == dsd_pkg::CHAMBER_TEST_PHASE);

   // latch as the indicator tick ends
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         supply_low_held <= 1'h0;
      end else if (tick && standby_check && phase == dsd_pkg::LED_PHASE) begin
         supply_low_held <= supply_low_in;
      end
   end

   // pass clears; hardware update wins over software clear
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         fail_count <= 2'h0;
      end else if (tick && chamber_test) begin
         if (!chamber_fail_in) begin
            fail_count <= 2'h0;
         end else if (fail_count != dsd_pkg::FAIL_LIMIT) begin
            fail_count <= fail_count + 2'h1;
         end
      end else if (fail_clr) begin
         fail_count <= 2'h0;
      end
   end

   // supply chirp while the latched status is set
   assign supply_chirp  = standby_check & supply_low_held &
                          (phase == dsd_pkg::SUPPLY_CHIRP_PHASE);
   // chamber chirp offset from the supply chirp
   assign chamber_chirp = standby_check & (fail_count == dsd_pkg::FAIL_LIMIT) &
                          (phase == dsd_pkg::CHAMBER_CHIRP_PHASE);

   ////////////////////////////////////////////////////////////////////////////////
   // alarm horn cycle

   // local cycles finish, remote ones stop at once
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         horn_run   <= 1'h0;
         horn_local <= 1'h0;
         horn_cnt   <= 16'h0000;
      end else if (horn_run && !horn_local &&
                   mode != dsd_pkg::DSD_REMOTE && mode != dsd_pkg::DSD_LOCAL) begin
         horn_run <= 1'h0;
      end else if (tick) begin
         if (!horn_run || horn_cnt == HORN_CYCLE[15:0] - 16'h0001) begin
            horn_run   <= (mode == dsd_pkg::DSD_LOCAL) || (mode == dsd_pkg::DSD_REMOTE);
            horn_local <= (mode == dsd_pkg::DSD_LOCAL);
            horn_cnt   <= 16'h0000;
         end else begin
            horn_cnt <= horn_cnt + 16'h0001;
         end
      end
   end

   assign alarm_horn = horn_run & (horn_cnt < HORN_ON[15:0]);
   assign horn_now   = alarm_horn | supply_chirp | chamber_chirp;

   ////////////////////////////////////////////////////////////////////////////////
   // interconnect discharge

   // one second after a local alarm ends
   // loaded only when leaving local alarm
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         dis_cnt <= 8'h00;
      end else if (mode == dsd_pkg::DSD_LOCAL && next_mode != dsd_pkg::DSD_LOCAL) begin
         dis_cnt <= dsd_pkg::DISCHARGE_TICKS[7:0];
      end else if (tick && dis_cnt != 8'h00) begin
         dis_cnt <= dis_cnt - 8'h01;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // registered pin outputs

   assign route = diag & io_in;

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         io_out                   <= 1'h0;
         io_oe_n_out              <= 1'h1;
         io_discharge_out         <= 1'h0;
         chamber_supply_out       <= 1'h0;
         emitter_pulse_drive_out  <= 1'h0;
         photo_amp_en_out         <= 1'h0;
         high_gain_out            <= 1'h0;
         hysteresis_out           <= 1'h0;
         first_gain_pin_out       <= 1'h0;
         second_gain_pin_out      <= 1'h0;
         horn_drive_pin_out       <= 1'h0;
         indicator_out            <= 1'h0;
         smoke_sample_inhibit_out <= 1'h0;
         diag_mode_out            <= 1'h0;
      end else begin
         diag_mode_out    <= diag;
         io_out           <= (mode == dsd_pkg::DSD_LOCAL);
         io_oe_n_out      <= (mode != dsd_pkg::DSD_LOCAL);
         io_discharge_out <= (dis_cnt != 8'h00) & ~diag;
         // chamber supply held on, emitter each tick
         chamber_supply_out      <= diag | chamber_test;
         emitter_pulse_drive_out <= window & (diag | chamber_test);
         // amplifier gated by the emitter window
         photo_amp_en_out        <= window & (diag | chamber_test);
         // gain and output pin from threshold input
         high_gain_out       <= diag ? (route & supply_threshold_input_in) : chamber_test;
         first_gain_pin_out  <= route & ~supply_threshold_input_in & window;
         second_gain_pin_out <= route & supply_threshold_input_in & window;
         hysteresis_out <= diag ? (~supply_threshold_input_in & feed_in)
                                : (mode == dsd_pkg::DSD_LOCAL);
         // integrator state on the horn pin
         horn_drive_pin_out <= diag ? smoke_integrator_in : horn_now;
         // one tick indicator pulse per cycle
         indicator_out <= diag ? supply_low_in :
                          ((mode == dsd_pkg::DSD_STANDBY) & (phase == dsd_pkg::LED_PHASE));
         // sampling held off while the horn sounds
         smoke_sample_inhibit_out <= ~diag & horn_now;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // register slave: one wait cycle, answer in the second

   assign avs_waitrequest_out = (avs_read_in | avs_write_in) & ~ack;
   // a write lands at the edge that ends the wait, the one the master samples
   assign wr_ctrl  = avs_write_in & ack & (avs_address_in == dsd_pkg::REG_CTRL) &
                     avs_byteenable_in[0];
   // clear pulse is write-only and never stored
   assign fail_clr = wr_ctrl & avs_writedata_in[dsd_pkg::CTRL_FAIL_CLR_BIT];

   always_comb begin
      next_readdata = 32'h0000_0000;
      unique case (avs_address_in)
         dsd_pkg::REG_CTRL: begin
            next_readdata[dsd_pkg::CTRL_EXT_CLK_BIT]  = ctrl_ext_clk;
            next_readdata[dsd_pkg::CTRL_CHECK_EN_BIT] = ctrl_check_en;
         end
         dsd_pkg::REG_STATUS: begin
            next_readdata[7:0] = {dis_cnt != 8'h00, mode, chamber_chirp, supply_chirp,
                                  fail_count, supply_low_held};
         end
         dsd_pkg::REG_PHASE: begin
            next_readdata[11:0] = phase;
         end
         default: begin
            next_readdata = 32'h0000_0000;
         end
      endcase
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         ack              <= 1'h0;
         avs_readdata_out <= 32'h0000_0000;
      end else begin
         ack              <= (avs_read_in | avs_write_in) & ~ack;
         avs_readdata_out <= next_readdata;
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         ctrl_ext_clk  <= dsd_pkg::CTRL_EXT_CLK_RST;
         ctrl_check_en <= dsd_pkg::CTRL_CHECK_EN_RST;
      end else if (wr_ctrl) begin
         ctrl_ext_clk  <= avs_writedata_in[dsd_pkg::CTRL_EXT_CLK_BIT];
         ctrl_check_en <= avs_writedata_in[dsd_pkg::CTRL_CHECK_EN_BIT];
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // assertions

   a_supply_capture: assert property (@(posedge clk_in) disable iff (rst_in)
      tick && standby_check && phase == dsd_pkg::LED_PHASE
      |=> supply_low_held == $past(supply_low_in))
      else $error("supply-low status not latched at indicator end");

   a_supply_chirp: assert property (@(posedge clk_in) disable iff (rst_in)
      supply_chirp && !diag |=> horn_drive_pin_out)
      else $error("supply-low chirp missing");

   a_chamber_gain: assert property (@(posedge clk_in) disable iff (rst_in)
      chamber_test && !diag |=> high_gain_out && chamber_supply_out)
      else $error("chamber test without high gain");

   a_chamber_chirp: assert property (@(posedge clk_in) disable iff (rst_in)
      standby_check && fail_count == 2'h2 && phase == dsd_pkg::CHAMBER_CHIRP_PHASE
      |=> horn_drive_pin_out)
      else $error("chamber failure chirp missing");

   a_checks_skipped: assert property (@(posedge clk_in) disable iff (rst_in)
      mode == dsd_pkg::DSD_LOCAL || mode == dsd_pkg::DSD_REMOTE
      |=> $stable(supply_low_held))
      else $error("supply check ran during alarm");

   a_diag_sticky: assert property (@(posedge clk_in) disable iff (rst_in)
      diag |=> diag && diag_mode_out)
      else $error("diagnostic mode left without reset");

   a_diag_release: assert property (@(posedge clk_in) disable iff (rst_in)
      diag |=> io_oe_n_out && !io_discharge_out && chamber_supply_out)
      else $error("diagnostic pin state wrong");

   a_diag_gain_pin: assert property (@(posedge clk_in) disable iff (rst_in)
      diag && io_in && window |=> first_gain_pin_out != second_gain_pin_out)
      else $error("gain pin routing wrong");

   a_diag_horn: assert property (@(posedge clk_in) disable iff (rst_in)
      diag |=> horn_drive_pin_out == $past(smoke_integrator_in))
      else $error("horn pin not showing integrator");

   a_diag_led: assert property (@(posedge clk_in) disable iff (rst_in)
      diag |=> indicator_out == $past(supply_low_in))
      else $error("indicator not showing supply status");

   a_discharge_on: assert property (@(posedge clk_in) disable iff (rst_in)
      mode == dsd_pkg::DSD_LOCAL && next_mode == dsd_pkg::DSD_STANDBY
      |=> ##1 io_discharge_out)
      else $error("discharge not started after local alarm");

   a_inhibit_horn: assert property (@(posedge clk_in) disable iff (rst_in)
      horn_drive_pin_out && !diag_mode_out |-> smoke_sample_inhibit_out)
      else $error("smoke sampling allowed while horn sounds");

endmodule : dsd_supervisor

// ==== verification/dsd_analog_model.sv ====
`timescale 1ns/10ps
module dsd_analog_model (
   // clock
   input  wire logic clk_in,
   // fixture controls
   input  wire logic fail_mode_in,
   input  wire logic battery_low_in,
   // device side
   input  wire logic chamber_supply_in,
   input  wire logic high_gain_in,
   output logic      chamber_fail_out,
   output logic      supply_low_out
);
   // outside a chamber test the comparator output is meaningless, so it churns
   logic junk = 1'b0;
   always @(posedge clk_in) begin
      junk <= ~junk;
   end
   // valid result only in a high-gain test
   assign chamber_fail_out = (chamber_supply_in && high_gain_in) ? fail_mode_in : junk;
   assign supply_low_out   = battery_low_in;
endmodule : dsd_analog_model

// ==== verification/tb_detector_supervision_and_diagnostics.sv ====
`timescale 1ns/10ps
module tb_detector_supervision_and_diagnostics;
   localparam int TK = 4;
   localparam int CT = dsd_pkg::CYCLE_TICKS;
   logic        clk_in = 1'b0, rst_in = 1'b1, avs_read_in = 1'b0, avs_write_in = 1'b0;
   logic [3:0]  avs_address_in = 4'h0, avs_byteenable_in = 4'hF;
   logic [31:0] avs_writedata_in = 32'h0, avs_readdata_out, rng = 32'h16;
   logic        supply_low_in, chamber_fail_in, smoke_integrator_in = 1'b0, io_in = 1'b0;
   logic        local_alarm_in = 1'b0, remote_alarm_in = 1'b0, test_below_ground_in = 1'b0;
   logic        supply_threshold_input_in = 1'b0, feed_in = 1'b0, ext_osc_in = 1'b0;
   logic        fail_mode = 1'b1, batt = 1'b1, std = 1'b1, ep = 1'b0;
   logic        avs_waitrequest_out, io_out, io_oe_n_out, io_discharge_out;
   logic        chamber_supply_out, emitter_pulse_drive_out, photo_amp_en_out, high_gain_out;
   logic        hysteresis_out, first_gain_pin_out, second_gain_pin_out, horn_drive_pin_out;
   logic        indicator_out, smoke_sample_inhibit_out, diag_mode_out;
   int          miscompares = 0, num_checks = 0, hw = 0, lw = 0, dw = 0, leds = 0, emits = 0;
   longint      rise[$];
   logic [31:0] exp_q[$];

   always #2 clk_in = ~clk_in;

   dsd_supervisor #(.TICK_CYCLES(TK), .DIAG_CYCLES(6), .PULSE_CYCLES(2)) dsd_supervisor_inst (.*);
   dsd_analog_model dsd_analog_model_inst (.clk_in, .fail_mode_in(fail_mode),
      .battery_low_in(batt), .chamber_supply_in(chamber_supply_out),
      .high_gain_in(high_gain_out), .chamber_fail_out(chamber_fail_in),
      .supply_low_out(supply_low_in));

   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction : xs

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check

   // read: d is the expected word, taken off the queue by the monitor
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
      @(posedge clk_in);
      avs_address_in   <= a;
      avs_writedata_in <= d;
      avs_write_in     <= w;
      avs_read_in      <= !w;
      if (!w) exp_q.push_back(d);
      @(posedge clk_in);
      while (avs_waitrequest_out) @(posedge clk_in);
      avs_read_in  <= 1'b0;
      avs_write_in <= 1'b0;
   endtask : bus

   task automatic ticks(input int n);
      repeat (n * TK) @(posedge clk_in);
   endtask : ticks

   task automatic give_verdict;
      if (miscompares == 0 && num_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : give_verdict

   ////////////////////////////////////////////////////////////////////////////////
   always @(posedge clk_in) begin
      if (avs_read_in && !avs_waitrequest_out) check(avs_readdata_out, exp_q.pop_front());
      if (horn_drive_pin_out && !diag_mode_out) check(smoke_sample_inhibit_out, 1);
      if (diag_mode_out) check(photo_amp_en_out, emitter_pulse_drive_out);
      if (std && horn_drive_pin_out) hw++;
      else if (hw != 0) begin
         check(hw, TK);
         hw = 0;
      end
      if (hw == 1) rise.push_back($time);
      if (std && indicator_out) lw++;
      else if (lw != 0) begin
         check(lw, TK);
         leds++;
         lw = 0;
      end
      if (io_discharge_out) dw++;
      if (emitter_pulse_drive_out && !ep) emits++;
      ep = emitter_pulse_drive_out;
   end

   initial begin
      repeat (100000) @(posedge clk_in);
      miscompares++;
      give_verdict();
   end

   initial begin
      repeat (4) @(posedge clk_in);
      rst_in <= 1'b0;
      bus(0, 4'h0, 32'h2);
      bus(1, 4'hC, 32'hFF);
      bus(0, 4'hC, 32'h0);
      // supply low and failing chamber from the start
      ticks(CT + 3000);
      bus(0, 4'h4, 32'h5);
      check(rise.size(), 3);
      check(rise[1] - rise[0], CT * TK * 4);
      check(rise[2] - rise[1], dsd_pkg::OFFSET_TICKS * TK * 4);
      fail_mode <= 1'b0;
      batt      <= 1'b0;
      ticks(CT);
      bus(0, 4'h4, 32'h0);
      check(rise.size(), 3);
      check(leds, 3);
      // alarms: a whole cycle of local alarm with faults present
      std = 1'b0;
      batt      <= 1'b1;
      fail_mode <= 1'b1;
      local_alarm_in <= 1'b1;
      ticks(CT);
      bus(0, 4'h4, 32'h20);
      check({io_out, io_oe_n_out}, 2'h2);
      local_alarm_in <= 1'b0;
      dw = 0;
      ticks(200);
      check(dw >= (dsd_pkg::DISCHARGE_TICKS - 1) * TK && dw <= 127 * TK, 1);
      remote_alarm_in <= 1'b1;
      ticks(20);
      bus(0, 4'h4, 32'h60);
      remote_alarm_in <= 1'b0;
      dw = 0;
      ticks(200);
      check(dw, 0);
      // fixture holds test input across a tick
      test_below_ground_in <= 1'b1;
      ticks(2);
      test_below_ground_in <= 1'b0;
      bus(0, 4'h4, 32'h40);
      emits = 0;
      repeat (60) @(posedge clk_in);
      check(chamber_supply_out, 1);
      check(emits >= 9 && emits <= 11, 1);
      io_in <= 1'b1;
      repeat (8) begin
         rng = xs(rng);
         smoke_integrator_in <= rng[0];
         batt <= rng[1];
         supply_threshold_input_in <= rng[2];
         feed_in <= rng[3];
         repeat (3) @(posedge clk_in);
         check(horn_drive_pin_out, rng[0]);
         check(indicator_out, rng[1]);
         check(io_oe_n_out, 1);
         check(high_gain_out, rng[2]);
         check({second_gain_pin_out, first_gain_pin_out},
               emitter_pulse_drive_out ? rng[2] + 32'h1 : 32'h0);
         check(hysteresis_out, rng[3] & !rng[2]);
      end
      bus(1, 4'h0, 32'h3);
      repeat (20) @(posedge clk_in);
      emits = 0;
      repeat (3) begin
         repeat (20) @(posedge clk_in);
         ext_osc_in <= 1'b1;
         repeat (20) @(posedge clk_in);
         ext_osc_in <= 1'b0;
      end
      repeat (20) @(posedge clk_in);
      check(emits, 3);
      give_verdict();
   end
endmodule : tb_detector_supervision_and_diagnostics
